// ===== vlbp_pkg.sv
// constants, types and shared decode for the local bus port block
package vlbp_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL_IDX      = 8'h00;
  localparam logic [7:0]  REG_SELF_ACK_IDX  = 8'h01;
  localparam logic [7:0]  REG_STATUS_IDX    = 8'h02;
  localparam logic [7:0]  REG_WIN_FIRST_IDX = 8'h08;
  localparam logic [7:0]  REG_WIN_LAST_IDX  = 8'h0F;
  localparam int          NUM_WINDOWS       = 8;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          CTRL_FAIL_RELEASE_BIT = 0;
  localparam int          SELF_ACK_HOLD_LSB     = 0;
  localparam int          SELF_ACK_SETUP_LSB    = 8;
  localparam int          STAT_SYSFAIL_BIT      = 0;
  localparam int          STAT_MPORT_BUSY_BIT   = 1;
  localparam int          STAT_MPORT_LOCK_BIT   = 2;
  localparam int          STAT_SPORT_BUSY_BIT   = 3;
  localparam int          STAT_LEGACY_MAP_BIT   = 4;
  localparam int          STAT_LEGACY_DEC_BIT   = 5;
  localparam int          WIN_AM_LSB            = 2;
  localparam int          WIN_BASE_LSB          = 8;
  localparam logic [7:0]  SELF_ACK_DELAY_RST    = 8'h00;
  localparam logic [31:0] WIN_RST               = 32'h0000_0000;
  localparam logic [31:0] WIN_SPAN_UNIT         = 32'h0000_0100;

  // ---------------------------------------------------------------
  // address space constants
  // ---------------------------------------------------------------
  localparam logic [5:0]  AM_CRCSR         = 6'h2F;
  localparam logic [18:0] CSR_BASE_DEFAULT = 19'h7F800;
  localparam logic [18:0] CSR_BASE_LEGACY  = 19'h7FC00;
  localparam int          CSR_BLOCK_LSB    = 10;
  localparam int          APB_ADDR_W       = 12;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {CYC_D08, CYC_D16, CYC_D32, CYC_BAD} vlbp_cycle_t;
  typedef enum logic [0:0] {M_IDLE, M_BUSY} vlbp_mst_t;
  typedef enum logic [1:0] {S_IDLE, S_VME, S_END} vlbp_slv_t;

  typedef struct packed {
    vlbp_mst_t         mSt;
    logic              mReq;
    logic [29:0]       mAddr;
    logic [5:0]        mAm;
    logic [31:0]       mWr;
    logic [3:0]        mBv;
    logic              mRwn;
    logic              mLock;
    logic              mSelCrcsr;
    logic [7:0]        mSelWin;
    logic              mSelMstr;
    logic              coreDone;
    logic              coreErr;
    logic [31:0]       coreRd;
    vlbp_slv_t         sSt;
    logic              sAck;
    logic              sNack;
    logic [31:0]       sRd;
    logic              vReq;
    logic [29:0]       vAddr;
    logic [5:0]        vAm;
    logic [31:0]       vWr;
    vlbp_cycle_t       vCyc;
    logic              vRwn;
    logic              vHoldAs;
    logic              vAuto;
    logic              selfDtack;
    logic [7:0]        cnt;
    logic              sysfail;
    logic [7:0]        setupDly;
    logic [7:0]        holdDly;
    logic [7:0][31:0]  win;
    logic [31:0]       prdata;
    logic              pslverr;
  } vlbp_state_t;

  // byte-valid pattern to VME data cycle type
  function automatic vlbp_cycle_t cycleOf(input logic [3:0] bv);
    vlbp_cycle_t c;
    c = CYC_BAD;
    if (bv == 4'h1 || bv == 4'h2 || bv == 4'h4 || bv == 4'h8) begin
      c = CYC_D08;
    end else if (bv == 4'h3 || bv == 4'hC) begin
      c = CYC_D16;
    end else if (bv == 4'hF) begin
      c = CYC_D32;
    end
    return c;
  endfunction

endpackage

// ===== vlbp_ports.sv
// local bus master/slave ports with APB control registers
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module vlbp_ports
  import vlbp_pkg::*;
#(
  parameter logic [7:0]      OPT_WINDOW_PRESENT       = 8'hFF,
  parameter logic [7:0][3:0] OPT_WINDOW_SIZE_EXP      = '0,
  parameter logic            OPT_SYSFAIL_MODE         = 1'b0,
  parameter logic            OPT_RESCIND_ACK          = 1'b0,
  parameter logic            OPT_LEGACY_CSR_MAP       = 1'b0,
  parameter logic            OPT_LEGACY_WINDOW_DECODE = 1'b0
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // request from the core towards user memory
  input  wire logic                  coreReq,
  input  wire logic [29:0]           coreAddr,
  input  wire logic [5:0]            coreAddrModifier,
  input  wire logic [31:0]           coreDataWr,
  input  wire logic [3:0]            coreByteValid,
  input  wire logic                  coreRwn,
  input  wire logic                  coreFromMaster,
  output logic                       coreDone,
  output logic                       coreErr,
  output logic      [31:0]           coreDataRd,
  // local master port
  output logic                       mportAccReq,
  input  wire logic                  mportAccAck,
  output logic      [29:0]           mportAddr,
  output logic      [5:0]            mportAddrModifier,
  output logic      [31:0]           mportDataWr,
  input  wire logic [31:0]           mportDataRd,
  output logic                       mportRwn,
  output logic                       mportLock,
  output logic      [3:0]            mportByteValid,
  output logic                       mportSelCrcsr,
  output logic      [7:0]            mportSelWindow,
  output logic                       mportSelMaster,
  // local slave port
  input  wire logic                  sportAccReq,
  output logic                       sportAccAck,
  output logic                       sportAccNack,
  input  wire logic                  sportSelCsr,
  input  wire logic                  sportSelVme,
  input  wire logic [29:0]           sportAddr,
  input  wire logic [5:0]            sportAddrModifier,
  input  wire logic [31:0]           sportDataWr,
  output logic      [31:0]           sportDataRd,
  input  wire logic [3:0]            sportByteValid,
  input  wire logic                  sportRwn,
  input  wire logic                  sportLock,
  input  wire logic                  sportAutoAck,
  // vme master engine
  output logic                       vmeReq,
  output logic      [29:0]           vmeAddr,
  output logic      [5:0]            vmeAddrModifier,
  output logic      [31:0]           vmeDataWr,
  output logic      [1:0]            vmeCycle,
  output logic                       vmeRwn,
  output logic                       vmeHoldAs,
  output logic                       vmeSelfAck,
  output logic                       vmeRescindAck,
  input  wire logic                  vmeDone,
  input  wire logic [31:0]           vmeDataRd,
  input  wire logic                  vmeBerr,
  input  wire logic                  vmeAsReleased,
  // system failure
  input  wire logic                  sysResetIn,
  output logic                       sysfailOut
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  vlbp_state_t st_ff;
  vlbp_state_t nxt_st;
  logic [7:0]  winHit;
  logic [7:0]  apbIdx;
  logic        apbMapped;
  logic        apbWrite;
  logic        inUserCsr;
  logic [18:0] csrBase;

  function automatic logic regValid(input logic [7:0] idx);
    logic ok;
    ok = 1'b0;
    if (idx == REG_CTRL_IDX || idx == REG_SELF_ACK_IDX || idx == REG_STATUS_IDX) begin
      ok = 1'b1;
    end else if (idx >= REG_WIN_FIRST_IDX && idx <= REG_WIN_LAST_IDX) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  function automatic logic [31:0] regRead(input vlbp_state_t s, input logic [7:0] idx);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (idx == REG_SELF_ACK_IDX) begin
      d[SELF_ACK_SETUP_LSB +: 8] = s.setupDly;
      d[SELF_ACK_HOLD_LSB +: 8]  = s.holdDly;
    end else if (idx == REG_STATUS_IDX) begin
      d[STAT_SYSFAIL_BIT]    = s.sysfail;
      d[STAT_MPORT_BUSY_BIT] = s.mReq;
      d[STAT_MPORT_LOCK_BIT] = s.mLock;
      d[STAT_SPORT_BUSY_BIT] = (s.sSt != S_IDLE);
      d[STAT_LEGACY_MAP_BIT] = OPT_LEGACY_CSR_MAP;
      d[STAT_LEGACY_DEC_BIT] = OPT_LEGACY_WINDOW_DECODE;
    end else if (idx >= REG_WIN_FIRST_IDX && idx <= REG_WIN_LAST_IDX) begin
      d = s.win[idx[2:0]];
    end
    return d;
  endfunction

  function automatic logic [31:0] laneMerge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] bv);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (bv[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic vlbp_state_t regWrite(input vlbp_state_t s, input logic [7:0] idx,
                                           input logic [31:0] d, input logic [3:0] bv);
    vlbp_state_t r;
    logic [31:0] m;
    r = s;
    m = laneMerge(32'h0000_0000, d, bv);
    if (idx == REG_CTRL_IDX) begin
      if (m[CTRL_FAIL_RELEASE_BIT]) begin
        r.sysfail = 1'b0;
      end
    end else if (idx == REG_SELF_ACK_IDX) begin
      m = laneMerge({16'h0000, s.setupDly, s.holdDly}, d, bv);
      r.setupDly = m[SELF_ACK_SETUP_LSB +: 8];
      r.holdDly  = m[SELF_ACK_HOLD_LSB +: 8];
    end else if (idx >= REG_WIN_FIRST_IDX && idx <= REG_WIN_LAST_IDX) begin
      r.win[idx[2:0]] = laneMerge(s.win[idx[2:0]], d, bv);
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // window and CSR decode
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_WINDOWS; g++) begin : gen_win
      logic [31:0] span;
      logic [31:0] mask;
      logic        baseHit;
      logic        amHit;
      assign span    = WIN_SPAN_UNIT << OPT_WINDOW_SIZE_EXP[g];
      assign mask    = ~(span - 32'h0000_0001);
      assign baseHit = ((({coreAddr, 2'b00} ^ {st_ff.win[g][31:WIN_BASE_LSB], 8'h00})
                        & mask) == 32'h0000_0000);
      // legacy decode compares the base only; function decode also checks the modifier
      assign amHit   = OPT_LEGACY_WINDOW_DECODE ||
                       (st_ff.win[g][WIN_AM_LSB +: 6] == coreAddrModifier);
      assign winHit[g] = OPT_WINDOW_PRESENT[g] && baseHit && amHit;
    end
  endgenerate

  assign csrBase   = OPT_LEGACY_CSR_MAP ? CSR_BASE_LEGACY : CSR_BASE_DEFAULT;
  assign inUserCsr = (coreAddr[16:8] == csrBase[18:CSR_BLOCK_LSB]);
  assign apbIdx    = paddr[9:2];
  assign apbMapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) && regValid(apbIdx);
  assign apbWrite  = psel && penable && pwrite && apbMapped;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.sAck     = 1'b0;
    nxt_st.sNack    = 1'b0;
    nxt_st.coreDone = 1'b0;
    nxt_st.coreErr  = 1'b0;

    // apb: data prepared in setup phase, zero wait states
    if (psel && !penable) begin
      nxt_st.prdata  = apbMapped ? regRead(st_ff, apbIdx) : 32'h0000_0000;
      nxt_st.pslverr = !apbMapped;
    end
    if (apbWrite) begin
      nxt_st = regWrite(nxt_st, apbIdx, pwdata, 4'hF);
    end

    // lock ends when the strobe goes away after a read
    if (st_ff.mSt == M_IDLE && vmeAsReleased) begin
      nxt_st.mLock = 1'b0;
    end

    // master port
    case (st_ff.mSt)
      M_IDLE: begin
        if (coreReq) begin
          nxt_st.mSt       = M_BUSY;
          nxt_st.mReq      = 1'b1;
          nxt_st.mAddr     = coreAddr;
          nxt_st.mAm       = coreAddrModifier;
          nxt_st.mWr       = coreDataWr;
          nxt_st.mBv       = coreByteValid;
          nxt_st.mRwn      = coreRwn;
          nxt_st.mSelMstr  = coreFromMaster;
          nxt_st.mSelCrcsr = !coreFromMaster && coreAddrModifier == AM_CRCSR
                             && !inUserCsr;
          nxt_st.mSelWin   = (coreFromMaster || coreAddrModifier == AM_CRCSR)
                             ? 8'h00 : winHit;
          if (coreRwn && cycleOf(coreByteValid) != CYC_BAD) begin
            nxt_st.mLock = 1'b1;
          end
        end
      end
      M_BUSY: begin
        // all outputs held from the latch until the end
        if (mportAccAck || vmeBerr) begin
          nxt_st.mSt       = M_IDLE;
          nxt_st.mReq      = 1'b0;
          nxt_st.mSelCrcsr = 1'b0;
          nxt_st.mSelWin   = 8'h00;
          nxt_st.mSelMstr  = 1'b0;
          nxt_st.coreDone  = mportAccAck;
          nxt_st.coreErr   = !mportAccAck;
          if (mportAccAck && st_ff.mRwn) begin
            nxt_st.coreRd = mportDataRd;
          end
          if (!st_ff.mRwn || vmeBerr) begin
            nxt_st.mLock = 1'b0;
          end
        end
      end
      default: nxt_st.mSt = M_IDLE;
    endcase

    // slave port
    case (st_ff.sSt)
      S_IDLE: begin
        if (sportAccReq && sportSelCsr && !apbWrite) begin
          // only bits 7..0 of sportAddr select the register
          if (sportRwn) begin
            nxt_st.sRd = regRead(st_ff, sportAddr[7:0]);
          end else begin
            nxt_st = regWrite(nxt_st, sportAddr[7:0], sportDataWr, sportByteValid);
          end
          nxt_st.sAck = 1'b1;
          nxt_st.sSt  = S_END;
        end else if (sportAccReq && sportSelVme && !sportSelCsr
                     && cycleOf(sportByteValid) != CYC_BAD) begin
          nxt_st.sSt       = S_VME;
          nxt_st.vReq      = 1'b1;
          nxt_st.vAddr     = sportAddr;
          nxt_st.vAm       = sportAddrModifier;
          nxt_st.vWr       = sportDataWr;
          nxt_st.vCyc      = cycleOf(sportByteValid);
          nxt_st.vRwn      = sportRwn;
          nxt_st.vAuto     = sportAutoAck;
          nxt_st.selfDtack = 1'b0;
          nxt_st.cnt       = st_ff.setupDly;
          if (sportRwn && sportLock) begin
            nxt_st.vHoldAs = 1'b1;
          end
        end else if (sportAccReq && !sportSelCsr) begin
          // bad select or byte pattern: refuse with a single nack;
          // a CSR request that meets an APB write just waits a cycle
          nxt_st.sNack = 1'b1;
          nxt_st.sSt   = S_END;
        end
      end
      S_VME: begin
        if (vmeBerr) begin
          nxt_st.vReq      = 1'b0;
          nxt_st.selfDtack = 1'b0;
          nxt_st.vHoldAs   = 1'b0;
          nxt_st.sNack     = 1'b1;
          nxt_st.sSt       = S_END;
        end else if (st_ff.vAuto) begin
          // effective delays are the programmed values plus one
          if (st_ff.cnt != 8'h00) begin
            nxt_st.cnt = st_ff.cnt - 8'h01;
          end else if (!st_ff.selfDtack) begin
            nxt_st.selfDtack = 1'b1;
            nxt_st.cnt       = st_ff.holdDly;
          end else begin
            nxt_st.selfDtack = 1'b0;
            nxt_st.vReq      = 1'b0;
            nxt_st.sAck      = 1'b1;
            nxt_st.sSt       = S_END;
            if (!st_ff.vRwn) begin
              nxt_st.vHoldAs = 1'b0;
            end
          end
        end else if (vmeDone) begin
          nxt_st.vReq = 1'b0;
          nxt_st.sAck = 1'b1;
          nxt_st.sSt  = S_END;
          if (st_ff.vRwn) begin
            nxt_st.sRd = vmeDataRd;
          end else begin
            nxt_st.vHoldAs = 1'b0;
          end
        end
      end
      S_END: begin
        // user drops the request after seeing the pulse
        nxt_st.sSt = S_IDLE;
      end
      default: nxt_st.sSt = S_IDLE;
    endcase

    // a system reset re-arms the fail signal; it wins over a release
    if (sysResetIn && OPT_SYSFAIL_MODE) begin
      nxt_st.sysfail = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff          <= '0;
      st_ff.mSt      <= M_IDLE;
      st_ff.sSt      <= S_IDLE;
      st_ff.vCyc     <= CYC_D08;
      st_ff.setupDly <= SELF_ACK_DELAY_RST;
      st_ff.holdDly  <= SELF_ACK_DELAY_RST;
      st_ff.win      <= {NUM_WINDOWS{WIN_RST}};
      st_ff.sysfail  <= OPT_SYSFAIL_MODE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata            = st_ff.prdata;
  assign pready            = 1'b1;
  assign pslverr           = st_ff.pslverr;
  assign coreDone          = st_ff.coreDone;
  assign coreErr           = st_ff.coreErr;
  assign coreDataRd        = st_ff.coreRd;
  assign mportAccReq       = st_ff.mReq;
  assign mportAddr         = st_ff.mAddr;
  assign mportAddrModifier = st_ff.mAm;
  assign mportDataWr       = st_ff.mWr;
  assign mportRwn          = st_ff.mRwn;
  assign mportLock         = st_ff.mLock;
  assign mportByteValid    = st_ff.mBv;
  assign mportSelCrcsr     = st_ff.mSelCrcsr;
  assign mportSelWindow    = st_ff.mSelWin;
  assign mportSelMaster    = st_ff.mSelMstr;
  assign sportAccAck       = st_ff.sAck;
  assign sportAccNack      = st_ff.sNack;
  assign sportDataRd       = st_ff.sRd;
  assign vmeReq            = st_ff.vReq;
  assign vmeAddr           = st_ff.vAddr;
  assign vmeAddrModifier   = st_ff.vAm;
  assign vmeDataWr         = st_ff.vWr;
  assign vmeCycle          = st_ff.vCyc;
  assign vmeRwn            = st_ff.vRwn;
  assign vmeHoldAs         = st_ff.vHoldAs;
  assign vmeSelfAck        = st_ff.selfDtack;
  assign vmeRescindAck     = OPT_RESCIND_ACK;
  assign sysfailOut        = st_ff.sysfail;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_ack_one_cycle:  assert property (sportAccAck |=> !sportAccAck)
    else $error("slave ack longer than one cycle");
  a_ack_nack_excl:  assert property (!(sportAccAck && sportAccNack))
    else $error("slave ack and nack together");
  a_berr_abort:     assert property (st_ff.sSt == S_VME && vmeBerr |=>
                                     sportAccNack ##1 !sportAccNack)
    else $error("bus error did not give a single nack");
  a_mport_stable:   assert property (mportAccReq && !mportAccAck && !vmeBerr |=>
                                     mportAccReq && $stable(mportAddr)
                                     && $stable(mportAddrModifier)
                                     && $stable(mportByteValid) && $stable(mportRwn))
    else $error("master port changed during access");
  a_lock_on_read:   assert property (st_ff.mSt == M_IDLE && coreReq && coreRwn &&
                                     cycleOf(coreByteValid) != CYC_BAD |=> mportLock)
    else $error("lock not raised on read");
  a_csr_ack:        assert property (st_ff.sSt == S_IDLE && sportAccReq &&
                                     sportSelCsr && !apbWrite |=> sportAccAck ##1 !sportAccAck)
    else $error("CSR access not acknowledged in one cycle");
  a_cycle_type:     assert property ($rose(vmeReq) |->
                                     vmeCycle == cycleOf($past(sportByteValid)))
    else $error("VME cycle type does not match byte valid");
  a_sel_exclusive:  assert property (mportSelCrcsr |->
                                     mportSelWindow == 8'h00 && !mportSelMaster)
    else $error("CR/CSR select overlaps another select");
  a_sysfail_reset:  assert property ($fell(reset) |-> sysfailOut == OPT_SYSFAIL_MODE)
    else $error("fail signal wrong after reset");

  c_csr_access:     cover property (sportAccReq && sportSelCsr ##1 sportAccAck);
  c_vme_nack:       cover property (vmeReq && vmeBerr ##1 sportAccNack);
  c_self_ack:       cover property ($rose(vmeSelfAck));
  c_locked_read:    cover property (mportLock && mportAccAck && mportRwn);

endmodule

// ===== vlbp_ports_tb.sv
// self-checking bench for the local bus ports
`timescale 1ns/100ps
module vlbp_ports_tb;
  import vlbp_pkg::*;
  logic clk_sys=0, reset=1, psel=0, penable=0, pwrite=0, coreReq=0, coreRwn=0;
  logic coreFromMaster=0, sportAccReq=0, sportSelCsr=0, sportSelVme=0, sportRwn=1;
  logic sportLock=0, sportAutoAck=0, vmeDone=0, vmeBerr=0, vmeAsReleased=0, sysResetIn=0;
  logic pready, pslverr, coreDone, coreErr, mportAccReq, mportRwn, mportLock, mportAccAck;
  logic mportSelCrcsr, mportSelMaster, sportAccAck, sportAccNack, vmeReq, vmeRwn;
  logic vmeHoldAs, vmeSelfAck, vmeRescindAck, sysfailOut;
  logic [1:0] vmeCycle;
  logic [3:0] coreByteValid=0, sportByteValid=0, mportByteValid, waitCnt=0;
  logic [5:0] coreAddrModifier=0, sportAddrModifier=0, mportAddrModifier, vmeAddrModifier;
  logic [7:0] mportSelWindow;
  logic [11:0] paddr=0;
  logic [29:0] coreAddr=0, sportAddr=0, mportAddr, vmeAddr;
  logic [31:0] pwdata=0, prdata, coreDataWr=0, coreDataRd, mportDataWr, mportDataRd;
  logic [31:0] sportDataWr=0, sportDataRd, vmeDataWr, vmeDataRd=0;
  int errors=0, checks=0;
  vlbp_ports #(.OPT_SYSFAIL_MODE(1'b1)) dut (.*);
  vlbp_user_mem mem (.*);
  initial forever #12.5 clk_sys = ~clk_sys;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, e, input logic er);
    @(posedge clk_sys);
    psel<=1; pwrite<=w; paddr<=a; pwdata<=d;
    @(posedge clk_sys);
    penable<=1;
    // pready is judged at the edge; only the watchdog ends a hang
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel<=0; penable<=0;
    if (!w) chk("prdata", e, prdata);
    chk("pslverr", er, pslverr);
  endtask
  task mst(input logic rw, fm, input logic [5:0] am, input logic [29:0] a,
           input logic [31:0] d, input logic [3:0] b, input logic [8:0] es);
    int i;
    @(posedge clk_sys);
    coreReq<=1; coreRwn<=rw; coreAddr<=a; coreDataWr<=d; coreByteValid<=b; coreFromMaster<=fm;
    coreAddrModifier<=am;
    @(posedge clk_sys);
    coreReq<=0;
    for (i=0; i<20 && coreDone!==1'b1; i++) begin
      @(posedge clk_sys);
      if (mportAccReq === 1'b1) begin
        chk("maddr", {2'h0, a}, {2'h0, mportAddr});
        chk("mam", am, mportAddrModifier);
        chk("mwr", d, mportDataWr);
        chk("mbv", b, mportByteValid);
        chk("mrwn", rw, mportRwn);
        chk("msel", fm, mportSelMaster);
        chk("mselx", es, {mportSelCrcsr, mportSelWindow});
      end
    end
    chk("done", 1, coreDone);
    chk("err", 0, coreErr);
    chk("lock", rw, mportLock);
    if (rw) chk("rdata", d, coreDataRd);
  endtask
  task fail_test;
    chk("sysfail", 1, sysfailOut);
    apb(0, 12'h008, 32'h0, 32'h0000_0001, 0);
    apb(1, 12'h000, 32'h0000_0001, 32'h0, 0);
    @(posedge clk_sys);
    chk("released", 0, sysfailOut);
    sysResetIn<=1;
    @(posedge clk_sys);
    sysResetIn<=0;
    @(posedge clk_sys);
    chk("rearmed", 1, sysfailOut);
    chk("rescind", 0, vmeRescindAck);
    $display("fail test done");
  endtask
  task slv(input logic v, input logic [29:0] a, input logic [3:0] b, input logic be,
           input logic [31:0] e, input logic [1:0] cy);
    int i;
    int n;
    @(posedge clk_sys);
    n = 0;
    sportAccReq<=1; sportSelVme<=v; sportSelCsr<=!v; sportAddr<=a; sportByteValid<=b;
    vmeDataRd<=e; sportDataWr<=e; sportAddrModifier<=a[5:0];
    for (i=0; i<20 && (sportAccAck|sportAccNack)!==1'b1; i++) begin
      @(posedge clk_sys);
      vmeDone<=vmeReq&!be&!vmeDone;
      vmeBerr<=vmeReq&be&!vmeBerr;
      if (vmeReq === 1'b1) begin
        chk("cycle", cy, vmeCycle);
        chk("vaddr", {a, sportRwn}, {vmeAddr, vmeRwn});
        chk("vam", a[5:0], vmeAddrModifier);
        chk("vwr", e, vmeDataWr);
      end
      if (vmeSelfAck === 1'b1) n++;
    end
    sportAccReq<=0;
    chk("ack", !be, sportAccAck);
    chk("nack", be, sportAccNack);
    if (!be && sportRwn) chk("srd", e, sportDataRd);
    // hold delay 2 programmed below, plus one
    chk("selfack", sportAutoAck ? 32'h3 : 32'h0, n);
    @(posedge clk_sys);
    chk("pulse", 0, sportAccAck|sportAccNack);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat(8) @(posedge clk_sys);
    reset<=0;
    fail_test;
    apb(1, 12'h004, 32'h0000_0102, 32'h0, 0);
    apb(0, 12'h004, 32'h0, 32'h0000_0102, 0);
    apb(0, 12'h00C, 32'h0, 32'h0, 1);
    // window 0: base 0x1200, modifier 0x09
    apb(1, 12'h020, 32'h0000_1224, 32'h0, 0);
    apb(0, 12'h020, 32'h0, 32'h0000_1224, 0);
    $display("apb test done");
    waitCnt<=4'h3;
    mst(0, 1, 6'h00, 30'h0000_1234, 32'hA5A5_0F0F, 4'hC, 9'h000);
    waitCnt<=4'h0;
    mst(1, 1, 6'h00, 30'h0000_1234, 32'hA5A5_0F0F, 4'hF, 9'h000);
    vmeAsReleased<=1;
    repeat(2) @(posedge clk_sys);
    chk("unlock", 0, mportLock);
    vmeAsReleased<=0;
    mst(0, 0, 6'h2F, 30'h0000_1234, 32'h0000_0011, 4'hF, 9'h100);
    mst(0, 0, 6'h2F, 30'h0001_FE00, 32'h0000_0022, 4'hF, 9'h000);
    mst(0, 0, 6'h09, 30'h0000_0480, 32'h0000_0033, 4'hF, 9'h001);
    mst(0, 0, 6'h09, 30'h0000_04C0, 32'h0000_0044, 4'hF, 9'h000);
    $display("master test done");
    // upper address bits are junk on purpose: only the index counts
    slv(0, 30'h3FFF_FC01, 4'hF, 0, 32'h0000_0102, 2'h0);
    slv(1, 30'h0000_0400, 4'h3, 0, 32'h1234_5678, 2'h1);
    slv(1, 30'h0000_0400, 4'h1, 1, 32'h0, 2'h0);
    sportLock<=1;
    slv(1, 30'h0000_0400, 4'hF, 0, 32'h8765_4321, 2'h2);
    chk("holdas", 1, vmeHoldAs);
    sportLock<=0;
    sportRwn<=0;
    slv(0, 30'h0000_0001, 4'h2, 0, 32'h0000_0300, 2'h0);
    apb(0, 12'h004, 32'h0, 32'h0000_0302, 0);
    sportAutoAck<=1;
    slv(1, 30'h0000_0400, 4'hF, 0, 32'h0000_00A5, 2'h2);
    chk("holdas", 0, vmeHoldAs);
    $display("slave test done");
    end_sim;
  end
  initial begin
    repeat(5000) @(posedge clk_sys);
    errors++;
    end_sim;
  end
endmodule

// ===== vlbp_user_mem.sv
// user-side memory answering the local master port
`timescale 1ns/100ps
module vlbp_user_mem (
  // master port
  input  wire logic        clk_sys,
  input  wire logic        mportAccReq,
  input  wire logic        mportRwn,
  input  wire logic [31:0] mportDataWr,
  input  wire logic [3:0]  waitCnt,
  output logic             mportAccAck = 1'b0,
  output logic      [31:0] mportDataRd = 32'h0
);
  logic [31:0] mem = 32'h0;
  logic [3:0]  cnt = 4'h0;
  always @(posedge clk_sys) begin
    // toggles off the ack edge so stale data never looks valid
    mportDataRd <= ~mportDataRd;
    mportAccAck <= 1'b0;
    cnt <= 4'h0;
    if (mportAccReq && !mportAccAck) begin
      cnt <= cnt + 4'h1;
      if (cnt == waitCnt) begin
        mportAccAck <= 1'b1;
        mportDataRd <= mem;
        if (!mportRwn) mem <= mportDataWr;
      end
    end
  end
endmodule
